// ==== logic/sync2.sv ====
// Purpose: Two-flop level synchroniser.
// Assumes: Inputs are levels from another clock domain or from pins.
// Notes: The first stage is read by the second stage only.
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  if (WIDTH < 1) begin : g_bad_width
    $error("sync2 needs WIDTH of at least one");
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ==== logic/toggle_pulse.sv ====
// Purpose: Turns a toggle from another domain into a one-cycle pulse.
// Assumes: The source toggles no faster than every few destination cycles.
// Notes: Edge detection looks only at the second stage.
`timescale 1ns/1ps
`default_nettype none
module toggle_pulse (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic tgl_in,
  output var  logic pulse
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= tgl_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign pulse = sync_reg ^ last_reg;
endmodule
`default_nettype wire

// ==== logic/twowire_ctrl.sv ====
// Purpose: Two-wire port with a software-driven master and a hardware slave.
// Assumes: Register bus on clk; slave engine on link_clk, which oversamples the pins.
// Notes: The own slave address comes in from elsewhere, the general call address is fixed; pad muxing with SPI is outside.
`timescale 1ns/1ps
`default_nettype none
module twowire_ctrl
  import twowire_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       link_clk,
  input  wire logic       link_rst,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output var  logic [7:0] sfr_rdata,
  input  wire logic [6:0] own_addr,
  input  wire logic       spi_port_enable,
  input  wire logic       spi_relocated,
  output var  logic       pins_owned,
  output var  logic       byte_done_irq,
  input  wire logic       serial_data_pin_i,
  output var  logic       serial_data_pin_o,
  output var  logic       serial_data_pin_oe,
  input  wire logic       serial_clock_pin_i,
  output var  logic       serial_clock_pin_o,
  output var  logic       serial_clock_pin_oe
);

  // Core clock domain state.
  logic       master_role_select_reg;
  logic       sw_data_out_reg;
  logic       sw_data_drive_en_reg;
  logic       sw_clock_out_reg;
  logic       sw_data_in_reg;
  logic       stop_irq_enable_reg;
  logic       general_call_flag_reg;
  logic [1:0] irq_source_reg;
  logic       iface_reset_bit_reg;
  logic       tx_dir_reg;
  logic       byte_done_flag_reg;
  logic [7:0] byte_data_reg;
  logic [7:0] rdata_reg;
  logic       release_tgl_reg;
  logic       sys_scl_last_reg;
  pin_pair_t  sys_pins;
  logic       evt_pulse;
  logic       grant;
  logic       ctl_wr;
  logic       data_access;
  logic       evt_take;
  logic       stop_evt;
  logic       set_done;
  logic       slave_on_sys;
  logic [7:0] ctl_view;

  // Link clock domain state.
  slave_state_t state_reg;
  logic [7:0]   shift_reg;
  logic [3:0]   cnt_reg;
  logic         sda_low_reg;
  logic         scl_low_reg;
  logic         tx_reg;
  logic         data_phase_reg;
  logic         rstart_reg;
  logic         matched_reg;
  logic         acked_reg;
  logic         gcall_hit_reg;
  logic         scl_d_reg;
  logic         sda_d_reg;
  slave_evt_t   evt_reg;
  logic         evt_tgl_reg;
  pin_pair_t    link_pins;
  logic         slave_on;
  logic         release_pulse;
  logic         scl_rise;
  logic         scl_fall;
  logic         start_c;
  logic         stop_c;
  logic         addr_hit;
  logic         gcall_hit;

  function automatic logic addr_is(input logic [7:0] frame, input logic [6:0] want);
    addr_is = (frame[7:1] == want);
  endfunction

  assign grant        = !spi_port_enable || spi_relocated;
  assign pins_owned   = grant;
  assign slave_on_sys = grant && !master_role_select_reg && !iface_reset_bit_reg;
  assign ctl_wr       = sfr_wr && (sfr_addr == CTL_ADDR);
  assign data_access  = (sfr_wr || sfr_rd) && (sfr_addr == DATA_ADDR);
  assign evt_take     = evt_pulse && !master_role_select_reg;
  assign stop_evt     = evt_take && (evt_reg.source == SRC_STOP);
  assign set_done     = evt_take && (!stop_evt || stop_irq_enable_reg);
  assign byte_done_irq = byte_done_flag_reg;

  // Pins seen by the software master.
  sync2 #(
    .WIDTH (2)
  ) u_sys_pins (
    .clk (clk),
    .rst (sys_rst),
    .d   ({serial_clock_pin_i, serial_data_pin_i}),
    .q   (sys_pins)
  );

  toggle_pulse u_evt_cross (
    .clk    (clk),
    .rst    (sys_rst),
    .tgl_in (evt_tgl_reg),
    .pulse  (evt_pulse)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      master_role_select_reg <= CTL_RESET[CTL_ROLE_BIT];
    end else if (ctl_wr) begin
      master_role_select_reg <= sfr_wdata[CTL_ROLE_BIT];
    end
  end

  // Master pin controls; writes in slave mode land in the slave fields instead.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sw_data_out_reg      <= CTL_RESET[CTL_DATA_OUT_BIT];
      sw_data_drive_en_reg <= CTL_RESET[CTL_DRIVE_EN_BIT];
      sw_clock_out_reg     <= CTL_RESET[CTL_CLOCK_OUT_BIT];
    end else if (ctl_wr && master_role_select_reg) begin
      sw_data_out_reg      <= sfr_wdata[CTL_DATA_OUT_BIT];
      sw_data_drive_en_reg <= sfr_wdata[CTL_DRIVE_EN_BIT];
      sw_clock_out_reg     <= sfr_wdata[CTL_CLOCK_OUT_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sys_scl_last_reg <= 1'b0;
      sw_data_in_reg   <= CTL_RESET[CTL_DATA_IN_BIT];
    end else begin
      sys_scl_last_reg <= sys_pins.scl;
      if (master_role_select_reg && !sw_data_drive_en_reg && sys_pins.scl && !sys_scl_last_reg) begin
        sw_data_in_reg <= sys_pins.sda;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stop_irq_enable_reg <= CTL_RESET[CTL_STOP_IRQ_BIT];
      iface_reset_bit_reg <= CTL_RESET[CTL_IFACE_RST_BIT];
    end else if (ctl_wr && !master_role_select_reg) begin
      stop_irq_enable_reg <= sfr_wdata[CTL_STOP_IRQ_BIT];
      iface_reset_bit_reg <= sfr_wdata[CTL_IFACE_RST_BIT];
    end
  end

  // Hardware set wins over a software clear in the same cycle.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      general_call_flag_reg <= CTL_RESET[CTL_GCALL_BIT];
    end else if (evt_take && evt_reg.gcall && !stop_evt) begin
      general_call_flag_reg <= 1'b1;
    end else if (ctl_wr && !master_role_select_reg && !sfr_wdata[CTL_GCALL_BIT]) begin
      general_call_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_source_reg <= {CTL_RESET[CTL_SRC_HI_BIT], CTL_RESET[CTL_SRC_LO_BIT]};
      tx_dir_reg     <= CTL_RESET[CTL_TX_DIR_BIT];
    end else if (set_done) begin
      irq_source_reg <= evt_reg.source;
      tx_dir_reg     <= evt_reg.tx_dir;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      byte_done_flag_reg <= CTL_RESET[CTL_BYTE_DONE_BIT];
    end else if (set_done) begin
      byte_done_flag_reg <= 1'b1;
    end else if (data_access) begin
      byte_done_flag_reg <= 1'b0;
    end
  end

  // The release toggle also frees a held clock; the data byte is already stable.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      release_tgl_reg <= 1'b0;
    end else if (data_access && byte_done_flag_reg && !set_done) begin
      release_tgl_reg <= !release_tgl_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      byte_data_reg <= DATA_RESET;
    end else if (sfr_wr && (sfr_addr == DATA_ADDR)) begin
      byte_data_reg <= sfr_wdata;
    end else if (evt_take && !stop_evt && !(evt_reg.source == SRC_USER_DATA && evt_reg.tx_dir)) begin
      byte_data_reg <= evt_reg.byte_val;
    end
  end

  always_comb begin
    if (master_role_select_reg) begin
      ctl_view = {sw_data_out_reg, sw_data_drive_en_reg, sw_clock_out_reg, sw_data_in_reg,
                  1'b1, 3'h0};
    end else begin
      ctl_view = {stop_irq_enable_reg, general_call_flag_reg, irq_source_reg, 1'b0,
                  iface_reset_bit_reg, tx_dir_reg, byte_done_flag_reg};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_reg <= 8'h00;
    end else if (sfr_rd && (sfr_addr == CTL_ADDR)) begin
      rdata_reg <= ctl_view;
    end else if (sfr_rd && (sfr_addr == DATA_ADDR)) begin
      rdata_reg <= byte_data_reg;
    end else if (sfr_rd) begin
      rdata_reg <= 8'h00;
    end
  end

  assign sfr_rdata = rdata_reg;

  // Pin drive: a gate of flops from both domains; it can only glitch at a role change.
  always_comb begin
    if (master_role_select_reg) begin
      serial_data_pin_o   = sw_data_out_reg;
      serial_data_pin_oe  = grant && sw_data_drive_en_reg;
      serial_clock_pin_o  = sw_clock_out_reg;
      serial_clock_pin_oe = grant;
    end else begin
      serial_data_pin_o   = 1'b0;
      serial_data_pin_oe  = grant && sda_low_reg;
      serial_clock_pin_o  = 1'b0;
      serial_clock_pin_oe = grant && scl_low_reg;
    end
  end

  // Link domain: the slave engine oversamples both lines.
  sync2 #(
    .WIDTH (2)
  ) u_link_pins (
    .clk (link_clk),
    .rst (link_rst),
    .d   ({serial_clock_pin_i, serial_data_pin_i}),
    .q   (link_pins)
  );

  sync2 #(
    .WIDTH (1)
  ) u_slave_on (
    .clk (link_clk),
    .rst (link_rst),
    .d   (slave_on_sys),
    .q   (slave_on)
  );

  toggle_pulse u_release_cross (
    .clk    (link_clk),
    .rst    (link_rst),
    .tgl_in (release_tgl_reg),
    .pulse  (release_pulse)
  );

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= link_pins.scl;
      sda_d_reg <= link_pins.sda;
    end
  end

  assign scl_rise  = link_pins.scl && !scl_d_reg;
  assign scl_fall  = !link_pins.scl && scl_d_reg;
  assign start_c   = link_pins.scl && scl_d_reg && sda_d_reg && !link_pins.sda;
  assign stop_c    = link_pins.scl && scl_d_reg && !sda_d_reg && link_pins.sda;
  assign gcall_hit = addr_is(shift_reg, GCALL_ADDR);
  assign addr_hit  = addr_is(shift_reg, own_addr) || gcall_hit;

  always_ff @(posedge link_clk) begin
    if (link_rst || !slave_on) begin
      state_reg      <= ST_IDLE;
      shift_reg      <= 8'h00;
      cnt_reg        <= 4'h0;
      sda_low_reg    <= 1'b0;
      scl_low_reg    <= 1'b0;
      tx_reg         <= 1'b0;
      data_phase_reg <= 1'b0;
      rstart_reg     <= 1'b0;
      matched_reg    <= 1'b0;
      acked_reg      <= 1'b0;
      gcall_hit_reg  <= 1'b0;
    end else if (start_c) begin
      state_reg      <= ST_ADDR;
      rstart_reg     <= (state_reg != ST_IDLE);
      cnt_reg        <= 4'h0;
      sda_low_reg    <= 1'b0;
      scl_low_reg    <= 1'b0;
      data_phase_reg <= 1'b0;
    end else if (stop_c) begin
      state_reg   <= ST_IDLE;
      sda_low_reg <= 1'b0;
      scl_low_reg <= 1'b0;
      matched_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          cnt_reg <= 4'h0;
        end
        ST_ADDR: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], link_pins.sda};
            cnt_reg   <= cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == BYTE_BITS) begin
            if (addr_hit) begin
              sda_low_reg   <= 1'b1;
              tx_reg        <= shift_reg[0];
              matched_reg   <= 1'b1;
              gcall_hit_reg <= gcall_hit;
              state_reg     <= ST_ACK;
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            sda_low_reg <= 1'b0;
            scl_low_reg <= 1'b1;
            state_reg   <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (release_pulse) begin
            scl_low_reg    <= 1'b0;
            cnt_reg        <= 4'h0;
            data_phase_reg <= 1'b1;
            state_reg      <= ST_DATA;
            if (tx_reg) begin
              shift_reg   <= byte_data_reg;
              sda_low_reg <= !byte_data_reg[7];
            end
          end
        end
        ST_DATA: begin
          if (tx_reg) begin
            if (scl_fall && cnt_reg == LAST_TX_BIT) begin
              sda_low_reg <= 1'b0;
              state_reg   <= ST_DACK;
            end else if (scl_fall) begin
              sda_low_reg <= !shift_reg[6];
              shift_reg   <= {shift_reg[6:0], 1'b0};
              cnt_reg     <= cnt_reg + 4'h1;
            end
          end else if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], link_pins.sda};
            cnt_reg   <= cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == BYTE_BITS) begin
            sda_low_reg <= 1'b1;
            state_reg   <= ST_ACK;
          end
        end
        ST_DACK: begin
          if (scl_rise) begin
            acked_reg <= !link_pins.sda;
          end else if (scl_fall && acked_reg) begin
            scl_low_reg <= 1'b1;
            state_reg   <= ST_HOLD;
          end else if (scl_fall) begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Events stay stable until the next one; the held clock keeps them apart.
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      evt_reg     <= '0;
      evt_tgl_reg <= 1'b0;
    end else if (!slave_on) begin
      evt_tgl_reg <= evt_tgl_reg;
    end else if (stop_c && matched_reg) begin
      evt_reg.source <= SRC_STOP;
      evt_reg.gcall  <= 1'b0;
      evt_tgl_reg    <= !evt_tgl_reg;
    end else if (state_reg == ST_ACK && scl_fall) begin
      evt_reg.source   <= data_phase_reg ? SRC_USER_DATA
                        : (rstart_reg ? SRC_RSTART_MATCH : SRC_START_MATCH);
      evt_reg.gcall    <= gcall_hit_reg && !data_phase_reg;
      evt_reg.tx_dir   <= tx_reg;
      evt_reg.byte_val <= shift_reg;
      evt_tgl_reg      <= !evt_tgl_reg;
    end else if (state_reg == ST_DACK && scl_fall && acked_reg) begin
      evt_reg.source <= SRC_USER_DATA;
      evt_reg.gcall  <= 1'b0;
      evt_reg.tx_dir <= 1'b1;
      evt_tgl_reg    <= !evt_tgl_reg;
    end
  end

endmodule
`default_nettype wire

// ==== logic/twowire_pkg.sv ====
// Purpose: Shared constants and types for the two-wire control block.
// Assumes: An 8-bit special-function register bus on the core clock.
// Notes: Bit positions 7 to 3 are shared by the master view and the slave view; bits 2 to 0 exist in the slave view only.
package twowire_pkg;

  localparam logic [7:0] CTL_ADDR     = 8'he8;
  localparam logic [7:0] DATA_ADDR    = 8'h9a;
  localparam logic [7:0] CTL_RESET    = 8'h00;
  localparam logic [7:0] DATA_RESET   = 8'h00;

  localparam int CTL_DATA_OUT_BIT  = 7;
  localparam int CTL_DRIVE_EN_BIT  = 6;
  localparam int CTL_CLOCK_OUT_BIT = 5;
  localparam int CTL_DATA_IN_BIT   = 4;
  localparam int CTL_ROLE_BIT      = 3;
  localparam int CTL_IFACE_RST_BIT = 2;
  localparam int CTL_TX_DIR_BIT    = 1;
  localparam int CTL_BYTE_DONE_BIT = 0;
  localparam int CTL_STOP_IRQ_BIT  = 7;
  localparam int CTL_GCALL_BIT     = 6;
  localparam int CTL_SRC_HI_BIT    = 5;
  localparam int CTL_SRC_LO_BIT    = 4;

  localparam logic [1:0] SRC_START_MATCH  = 2'h0;
  localparam logic [1:0] SRC_RSTART_MATCH = 2'h1;
  localparam logic [1:0] SRC_USER_DATA    = 2'h2;
  localparam logic [1:0] SRC_STOP         = 2'h3;

  localparam logic [6:0] GCALL_ADDR   = 7'h00;
  localparam logic [3:0] BYTE_BITS    = 4'h8;
  localparam logic [3:0] LAST_TX_BIT  = 4'h7;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_ACK  = 6'h04,
    ST_HOLD = 6'h08,
    ST_DATA = 6'h10,
    ST_DACK = 6'h20
  } slave_state_t;

  typedef struct packed {
    logic [1:0] source;
    logic       gcall;
    logic       tx_dir;
    logic [7:0] byte_val;
  } slave_evt_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } pin_pair_t;

endpackage

// ==== sim/testbench.sv ====
// Purpose: Self-checking bench for the two-wire control block.
// Assumes: Pull-ups on both lines; a behavioural master on the far side.
// Notes: Reset lasts ten core cycles, which covers three link clock edges.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import twowire_pkg::*;
;
  localparam logic [7:0] ADDR_W = 8'h58;
  logic       clk, link_clk, sys_rst, link_rst, sfr_wr, sfr_rd;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic       spi_port_enable, spi_relocated, pins_owned, byte_done_irq;
  logic       sda_o, sda_oe, scl_o, scl_oe, scl_low, sda_low, ack;
  wire logic  scl_w, sda_w;
  int         err_count, comparisons;
  assign scl_w = (scl_oe ? scl_o : 1'b1) & !scl_low;
  assign sda_w = (sda_oe ? sda_o : 1'b1) & !sda_low;
  twowire_ctrl uut (
    .clk, .sys_rst, .link_clk, .link_rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
    .sfr_rdata, .own_addr(ADDR_W[7:1]), .spi_port_enable, .spi_relocated, .pins_owned,
    .byte_done_irq, .serial_data_pin_i(sda_w), .serial_data_pin_o(sda_o),
    .serial_data_pin_oe(sda_oe), .serial_clock_pin_i(scl_w), .serial_clock_pin_o(scl_o),
    .serial_clock_pin_oe(scl_oe)
  );
  wire_master_model bm (.scl_w, .sda_w, .scl_low, .sda_low);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #40 link_clk = ~link_clk;
  end
  function automatic logic [7:0] b1(input logic v);
    return {7'h0, v};
  endfunction
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = w;
    sfr_rd    = !w;
    @(posedge clk);
    #1;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, m, e, input string what);
    acc(1'b0, a, 8'h00);
    chk(what, e, sfr_rdata & m);
  endtask
  task automatic wait_done();
    for (int n = 0; n < 4000 && byte_done_irq !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk("byte_done_irq", 8'h01, b1(byte_done_irq));
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic t_reset();
    rchk(CTL_ADDR, 8'hff, 8'h00, "ctl_reset");
    rchk(8'h55, 8'hff, 8'h00, "unmapped");
    $display("t_reset done");
  endtask
  task automatic t_master();
    acc(1'b1, CTL_ADDR, 8'h08);
    acc(1'b1, CTL_ADDR, 8'hef);
    chk("pins_high", 8'h0f, {4'h0, sda_oe, sda_o, scl_oe, scl_o});
    rchk(CTL_ADDR, 8'hef, 8'he8, "ctl_master");
    acc(1'b1, CTL_ADDR, 8'h48);
    chk("pins_low", 8'h0a, {4'h0, sda_oe, sda_o, scl_oe, scl_o});
    acc(1'b1, CTL_ADDR, 8'h08);
    chk("sda_input", 8'h00, b1(sda_oe));
    $display("t_master done");
  endtask
  task automatic t_sample();
    acc(1'b1, CTL_ADDR, 8'h28);
    repeat (8) @(posedge clk);
    rchk(CTL_ADDR, 8'h10, 8'h10, "data_in_high");
    bm.sda_low = 1'b1;
    acc(1'b1, CTL_ADDR, 8'h08);
    acc(1'b1, CTL_ADDR, 8'h28);
    repeat (8) @(posedge clk);
    rchk(CTL_ADDR, 8'h10, 8'h00, "data_in_low");
    bm.sda_low = 1'b0;
    acc(1'b1, CTL_ADDR, 8'hc8);
    acc(1'b1, CTL_ADDR, 8'he8);
    repeat (8) @(posedge clk);
    rchk(CTL_ADDR, 8'h10, 8'h00, "data_in_frozen");
    $display("t_sample done");
  endtask
  task automatic t_share();
    acc(1'b1, CTL_ADDR, 8'h28);
    spi_port_enable = 1'b1;
    @(posedge clk);
    #1;
    chk("spi_on", 8'h00, {5'h0, pins_owned, sda_oe, scl_oe});
    spi_relocated = 1'b1;
    @(posedge clk);
    #1;
    chk("spi_moved", 8'h05, {5'h0, pins_owned, sda_oe, scl_oe});
    {spi_port_enable, spi_relocated} = 2'b00;
    acc(1'b1, CTL_ADDR, 8'h00);
    $display("t_share done");
  endtask
  task automatic t_slave();
    bm.start_cond();
    bm.send_byte(ADDR_W, ack);
    chk("addr_ack", 8'h01, b1(ack));
    wait_done();
    chk("scl_stretch", 8'h01, b1(scl_oe));
    rchk(CTL_ADDR, 8'hff, 8'h01, "ctl_start");
    rchk(DATA_ADDR, 8'hff, ADDR_W, "addr_byte");
    chk("done_rd_clear", 8'h00, b1(byte_done_irq));
    bm.send_byte(8'ha5, ack);
    wait_done();
    rchk(CTL_ADDR, 8'hff, 8'h21, "ctl_data");
    rchk(DATA_ADDR, 8'hff, 8'ha5, "rx_byte");
    bm.start_cond();
    bm.send_byte(ADDR_W, ack);
    wait_done();
    rchk(CTL_ADDR, 8'hff, 8'h11, "ctl_rstart");
    acc(1'b1, DATA_ADDR, 8'h00);
    chk("done_wr_clear", 8'h00, b1(byte_done_irq));
    bm.stop_cond();
    repeat (100) @(posedge clk);
    chk("stop_quiet", 8'h00, b1(byte_done_irq));
    $display("t_slave done");
  endtask
  // Read transfer: the slave shifts the written byte out; the master NACKs it.
  task automatic t_read();
    bm.start_cond();
    bm.send_byte(ADDR_W | 8'h01, ack);
    wait_done();
    rchk(CTL_ADDR, 8'hff, 8'h03, "ctl_read");
    acc(1'b1, DATA_ADDR, 8'h7f);
    repeat (20) @(posedge clk);
    chk("tx_first_bit", 8'h01, b1(sda_oe));
    bm.send_byte(8'hff, ack);
    bm.stop_cond();
    repeat (100) @(posedge clk);
    chk("nack_quiet", 8'h00, b1(byte_done_irq));
    $display("t_read done");
  endtask
  task automatic t_gcall();
    acc(1'b1, CTL_ADDR, 8'h80);
    bm.start_cond();
    bm.send_byte(8'h00, ack);
    wait_done();
    rchk(CTL_ADDR, 8'hff, 8'hc1, "ctl_gcall");
    rchk(DATA_ADDR, 8'hff, 8'h00, "gcall_byte");
    bm.stop_cond();
    wait_done();
    rchk(CTL_ADDR, 8'hff, 8'hf1, "ctl_stop");
    rchk(DATA_ADDR, 8'hff, 8'h00, "stop_data");
    acc(1'b1, CTL_ADDR, 8'h80);
    rchk(CTL_ADDR, 8'h40, 8'h00, "gcall_cleared");
    $display("t_gcall done");
  endtask
  task automatic t_iface();
    acc(1'b1, CTL_ADDR, 8'h04);
    bm.start_cond();
    bm.send_byte(ADDR_W, ack);
    chk("ack_in_reset", 8'h00, b1(ack));
    bm.stop_cond();
    repeat (100) @(posedge clk);
    chk("quiet_in_reset", 8'h00, b1(byte_done_irq));
    rchk(CTL_ADDR, 8'h04, 8'h04, "iface_reset_bit");
    acc(1'b1, CTL_ADDR, 8'h00);
    $display("t_iface done");
  endtask
  initial begin
    {sys_rst, link_rst} = 2'b11;
    {sfr_wr, sfr_rd, spi_port_enable, spi_relocated} = 4'h0;
    sfr_addr    = 8'h00;
    sfr_wdata   = 8'h00;
    err_count   = 0;
    comparisons = 0;
    repeat (10) @(posedge clk);
    #1;
    {sys_rst, link_rst} = 2'b00;
    t_reset();
    t_master();
    t_sample();
    t_share();
    t_slave();
    t_read();
    t_gcall();
    t_iface();
    tally_and_finish();
  end
  // Whole run needs well under half of this span.
  initial begin
    #2000000;
    err_count++;
    $display("watchdog expired");
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ==== sim/twowire_checker.sv ====
// Purpose: Port-level checks of the two-wire control block.
// Assumes: All checks run on the core clock.
// Notes: Helper flops mirror the master pin bits from bus writes.
`timescale 1ns/1ps
`default_nettype none
module twowire_checker
  import twowire_pkg::*;
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       link_clk,
  input wire logic       link_rst,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic [6:0] own_addr,
  input wire logic       spi_port_enable,
  input wire logic       spi_relocated,
  input wire logic       pins_owned,
  input wire logic       byte_done_irq,
  input wire logic       serial_data_pin_i,
  input wire logic       serial_data_pin_o,
  input wire logic       serial_data_pin_oe,
  input wire logic       serial_clock_pin_i,
  input wire logic       serial_clock_pin_o,
  input wire logic       serial_clock_pin_oe
);
  logic       role_reg;
  logic       known_reg;
  logic [2:0] mb_reg;
  logic       dacc;
  assign dacc = (sfr_wr || sfr_rd) && sfr_addr == DATA_ADDR;
  // Master bits are trusted only after a write made while already master.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      role_reg  <= 1'b0;
      known_reg <= 1'b0;
      mb_reg    <= 3'h0;
    end else if (sfr_wr && sfr_addr == CTL_ADDR) begin
      role_reg  <= sfr_wdata[3];
      known_reg <= role_reg & sfr_wdata[3];
      mb_reg    <= sfr_wdata[7:5];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_unowned_quiet: assert property (
    !pins_owned |-> !serial_data_pin_oe && !serial_clock_pin_oe)
    else $error("pins driven while not owned");
  a_master_data: assert property (
    known_reg && pins_owned |-> serial_data_pin_oe == mb_reg[1]
    && (!mb_reg[1] || serial_data_pin_o == mb_reg[2]))
    else $error("master data pin wrong");
  a_master_clock: assert property (
    known_reg && pins_owned |-> serial_clock_pin_oe && serial_clock_pin_o == mb_reg[0])
    else $error("master clock pin wrong");
  a_slave_pulls_low: assert property (
    !role_reg |-> (!serial_data_pin_oe || !serial_data_pin_o)
    && (!serial_clock_pin_oe || !serial_clock_pin_o))
    else $error("slave drives a line high");
  a_ctl_readback: assert property (
    sfr_rd && sfr_addr == CTL_ADDR && known_reg |=> sfr_rdata[3:0] == 4'h8
    && sfr_rdata[7:5] == $past(mb_reg))
    else $error("master control readback wrong");
  a_done_clears: assert property (byte_done_irq && dacc |=> !byte_done_irq)
    else $error("byte done not cleared by data access");
  a_stretch_held: assert property (
    byte_done_irq && !role_reg && serial_clock_pin_oe |=> serial_clock_pin_oe)
    else $error("clock released while byte done set");
  a_stretch_release: assert property (
    $fell(byte_done_irq) && !role_reg |-> ##[0:40] !serial_clock_pin_oe)
    else $error("clock not released after clear");
  c_master_read: cover property (known_reg && sfr_rd && sfr_addr == CTL_ADDR);
  c_byte_event: cover property ($rose(byte_done_irq));
  c_release: cover property ($fell(byte_done_irq) && serial_clock_pin_oe);
endmodule
bind twowire_ctrl twowire_checker chk_i (
  .clk, .sys_rst, .link_clk, .link_rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
  .sfr_rdata, .own_addr, .spi_port_enable, .spi_relocated, .pins_owned, .byte_done_irq,
  .serial_data_pin_i, .serial_data_pin_o, .serial_data_pin_oe, .serial_clock_pin_i,
  .serial_clock_pin_o, .serial_clock_pin_oe
);
`default_nettype wire

// ==== sim/wire_master_model.sv ====
// Purpose: Behavioural two-wire bus master on the far side.
// Assumes: Open-drain lines resolved with pull-ups in the bench.
// Notes: Clock release waits, bounded, for a stretching slave.
`timescale 1ns/1ps
`default_nettype none
module wire_master_model #(
  parameter int HALF_NS = 640
) (
  input  wire logic scl_w,
  input  wire logic sda_w,
  output var  logic scl_low,
  output var  logic sda_low
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  task automatic rise();
    scl_low = 1'b0;
    for (int i = 0; i < 4000 && scl_w !== 1'b1; i++) begin
      #10;
    end
    #(HALF_NS);
  endtask
  task automatic start_cond();
    sda_low = 1'b0;
    #(HALF_NS);
    rise();
    sda_low = 1'b1;
    #(HALF_NS);
    scl_low = 1'b1;
  endtask
  task automatic stop_cond();
    sda_low = 1'b1;
    #(HALF_NS);
    rise();
    sda_low = 1'b0;
    #(HALF_NS);
  endtask
  // Bits go out MSB first; the ninth clock samples the slave's answer.
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      sda_low = (i > 0) ? !b[i-1] : 1'b0;
      #(HALF_NS);
      rise();
      ack = (sda_w === 1'b0);
      scl_low = 1'b1;
    end
  endtask
endmodule
`default_nettype wire
